// ### common/wolpm_pkg.sv
package wolpm_pkg;

  // Control bit positions and wake frame count.
  localparam int unsigned PORT_CHIP_POWERDOWN_IN_N_BIT  = 11;
  localparam int unsigned WFC_MAGIC_BIT   = 7;
  localparam int unsigned NUM_WAKE_FRAMES = 4;

  // Remote-wake pattern layout.
  localparam logic [7:0] SYNC_BYTE   = 8'hFF;
  localparam logic [2:0] SYNC_LEN    = 3'h6;
  localparam logic [2:0] ADDR_LEN    = 3'h6;
  localparam logic [2:0] ADDR_LAST   = 3'h5;
  localparam logic [4:0] ADDR_COPIES = 5'h10;
  localparam logic [2:0] DA_LEN      = 3'h6;

  // Reflected CRC-32 as used on the wire.
  localparam logic [31:0] CRC_INIT    = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY    = 32'hEDB88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;

  // Wake cause bit positions.
  localparam int unsigned CAUSE_LINK  = 0;
  localparam int unsigned CAUSE_FRAME = 1;
  localparam int unsigned CAUSE_MAGIC = 2;
  localparam int unsigned CAUSE_W     = 3;

  // Remote-wake scanner states, Gray coded along the usual path.
  typedef enum logic [1:0] {
    WOLPM_SCAN_SYNC  = 2'h0,
    WOLPM_SCAN_ADDR  = 2'h1,
    WOLPM_SCAN_FOUND = 2'h3
  } wolpm_scan_t;

endpackage

// ### src/wolpm_crc.sv
`timescale 1ns/1ns
`default_nettype none
module wolpm_crc (
  // Clock and reset.
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  // Byte stream.
  input  wire logic       i_clear,
  input  wire logic       i_valid,
  input  wire logic [7:0] i_data,
  // Check result.
  output logic            o_residue_ok
);
  import wolpm_pkg::*;

  logic [31:0] crc_r;
  logic [31:0] crc_nxt;

  // Folds one byte into the running CRC, least significant bit first.
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Restart at frame start, otherwise accumulate valid bytes.
  assign crc_nxt = i_clear ? CRC_INIT : (i_valid ? crc_byte(crc_r, i_data) : crc_r);

  // Running CRC register.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      crc_r <= CRC_INIT;
    end else begin
      crc_r <= crc_nxt;
    end
  end

  // A good frame including its FCS leaves the fixed residue behind.
  assign o_residue_ok = (crc_r == CRC_RESIDUE);

endmodule
`default_nettype wire

// ### src/wolpm_top.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// R1: Bit 11 of either control powers port down.
// R2: Chip power-down pin low powers chip down.
// R3: Pin rising edge powers up with chip reset.
// R4: Wake on link change, wake frame, pattern.
// R5: Wake frame recognised by stored CRC value.
// R6: Four wake frames, enabled by bits 0-3.
// R7: Bit 7 enables remote-wake pattern scanning.
// R8: Pattern needs sixteen uninterrupted station address copies.
// R9: Copies preceded by six FFh sync bytes.
// R10: Pattern found at any byte position.
// R11: Only valid frames: CRC good, proper DA.
// R12: Broadcast frames accepted when copies match.
// R13: Frame without full pattern gives no wake.
// R14: Complete pattern asserts active-low event output.
// R15: Event held until acknowledge; mismatch restarts scan.
module wolpm_top (
  // Clock and reset.
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  // Power control.
  input  wire logic [15:0] i_port_phy_control_four,
  input  wire logic [15:0] i_port_basic_control,
  input  wire logic        i_chip_powerdown_in_n,
  output logic             o_port_powerdown,
  output logic             o_chip_powerdown,
  output logic             o_chip_reset,
  // Wake configuration.
  input  wire logic [7:0]  i_wake_frame_control,
  input  wire logic [31:0] i_wake_crc [wolpm_pkg::NUM_WAKE_FRAMES],
  input  wire logic [47:0] i_station_addr,
  // Received frames and link status.
  input  wire logic        i_rx_start,
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  input  wire logic        i_rx_end,
  input  wire logic        i_link_up,
  // Host power management.
  input  wire logic        i_wake_ack,
  output logic             o_power_event_out_n,
  output logic [2:0]       o_wake_cause
);
  import wolpm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Power control.

  logic port_pd_r;
  logic chip_pd_r;
  logic chip_rst_r;
  logic pin_prev_r;
  logic port_pd_nxt;
  logic pin_rise;

  // Either control register may hold the port down.
  assign port_pd_nxt = i_port_phy_control_four[PORT_CHIP_POWERDOWN_IN_N_BIT]
                     | i_port_basic_control[PORT_CHIP_POWERDOWN_IN_N_BIT];  // see R1
  assign pin_rise    = i_chip_powerdown_in_n & ~pin_prev_r;    // see R3

  // Power state registers; chip reset is a one-cycle pulse on release.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      port_pd_r  <= 1'b0;
      chip_pd_r  <= 1'b0;
      chip_rst_r <= 1'b0;
      pin_prev_r <= 1'b1;
    end else begin
      port_pd_r  <= port_pd_nxt;
      chip_pd_r  <= ~i_chip_powerdown_in_n;  // see R2
      chip_rst_r <= pin_rise;                // see R3
      pin_prev_r <= i_chip_powerdown_in_n;
    end
  end

  assign o_port_powerdown = port_pd_r;
  assign o_chip_powerdown = chip_pd_r;
  assign o_chip_reset     = chip_rst_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Receive qualification, destination check and FCS capture.

  logic        rx_byte;
  logic        rx_clear;
  logic        magic_en;
  logic        crc_ok;
  logic [2:0]  da_idx_r;
  logic        da_own_r;
  logic        da_bcast_r;
  logic        da_mcast_r;
  logic [31:0] fcs_r;
  logic        in_da;
  logic        frame_ok;

  // Station address byte in wire order, byte 0 first.
  function automatic logic [7:0] addr_byte(input logic [47:0] a, input logic [2:0] i);
    logic [7:0] b;
    case (i)
      3'h0:    b = a[47:40];
      3'h1:    b = a[39:32];
      3'h2:    b = a[31:24];
      3'h3:    b = a[23:16];
      3'h4:    b = a[15:8];
      default: b = a[7:0];
    endcase
    return b;
  endfunction

  // Frames are ignored while the port or chip is powered down.
  assign rx_byte  = i_rx_valid & ~port_pd_r & ~chip_pd_r;
  assign rx_clear = i_rx_start;
  assign magic_en = i_wake_frame_control[WFC_MAGIC_BIT];  // see R7
  assign in_da    = (da_idx_r < DA_LEN);

  // Valid frame: good CRC and own, multicast or broadcast destination.
  assign frame_ok = crc_ok & ~in_da & (da_own_r | da_bcast_r | da_mcast_r);  // see R11 R12

  wolpm_crc u_crc (
    .i_clock      (i_clock),
    .i_reset      (i_reset),
    .i_clear      (rx_clear),
    .i_valid      (rx_byte),
    .i_data       (i_rx_data),
    .o_residue_ok (crc_ok)
  );

  // Destination tracking and last-four-byte capture of the FCS.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      da_idx_r   <= 3'h0;
      da_own_r   <= 1'b0;
      da_bcast_r <= 1'b0;
      da_mcast_r <= 1'b0;
      fcs_r      <= 32'h00000000;
    end else if (rx_clear) begin
      da_idx_r   <= 3'h0;
      da_own_r   <= 1'b1;
      da_bcast_r <= 1'b1;
      da_mcast_r <= 1'b0;
      fcs_r      <= 32'h00000000;
    end else if (rx_byte) begin
      fcs_r <= {i_rx_data, fcs_r[31:8]};
      if (in_da) begin
        da_idx_r   <= da_idx_r + 3'h1;
        da_own_r   <= da_own_r & (i_rx_data == addr_byte(i_station_addr, da_idx_r));
        da_bcast_r <= da_bcast_r & (i_rx_data == SYNC_BYTE);
        if (da_idx_r == 3'h0) begin
          da_mcast_r <= i_rx_data[0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Remote-wake pattern scanner.

  wolpm_scan_t scan_r;
  wolpm_scan_t scan_nxt;
  logic [2:0]  sync_cnt_r;
  logic [2:0]  sync_cnt_nxt;
  logic [2:0]  pos_r;
  logic [2:0]  pos_nxt;
  logic [4:0]  copy_cnt_r;
  logic [4:0]  copy_cnt_nxt;
  logic        is_sync;
  logic        is_addr;
  logic        scan_byte;

  assign is_sync   = (i_rx_data == SYNC_BYTE);
  assign is_addr   = (i_rx_data == addr_byte(i_station_addr, pos_r));
  assign scan_byte = rx_byte & magic_en;  // see R7 R10

  // Scanner next state; any mismatch falls back to hunting for sync.
  always_comb begin
    scan_nxt     = scan_r;
    sync_cnt_nxt = sync_cnt_r;
    pos_nxt      = pos_r;
    copy_cnt_nxt = copy_cnt_r;
    if (rx_clear) begin
      scan_nxt     = WOLPM_SCAN_SYNC;
      sync_cnt_nxt = 3'h0;
      pos_nxt      = 3'h0;
      copy_cnt_nxt = 5'h00;
    end else if (scan_byte) begin
      case (scan_r)
        WOLPM_SCAN_SYNC: begin
          if (sync_cnt_r == SYNC_LEN && is_addr) begin  // see R9
            scan_nxt     = WOLPM_SCAN_ADDR;
            pos_nxt      = 3'h1;
            copy_cnt_nxt = 5'h00;
          end else if (is_sync) begin
            sync_cnt_nxt = (sync_cnt_r == SYNC_LEN) ? SYNC_LEN : sync_cnt_r + 3'h1;
          end else begin
            sync_cnt_nxt = 3'h0;
          end
        end
        WOLPM_SCAN_ADDR: begin
          if (is_addr) begin
            if (pos_r == ADDR_LAST) begin
              pos_nxt      = 3'h0;
              copy_cnt_nxt = copy_cnt_r + 5'h01;
              if (copy_cnt_r + 5'h01 == ADDR_COPIES) begin  // see R8
                scan_nxt = WOLPM_SCAN_FOUND;
              end
            end else begin
              pos_nxt = pos_r + 3'h1;
            end
          end else begin
            scan_nxt     = WOLPM_SCAN_SYNC;  // see R15
            pos_nxt      = 3'h0;
            copy_cnt_nxt = 5'h00;
            sync_cnt_nxt = is_sync ? 3'h1 : 3'h0;
          end
        end
        WOLPM_SCAN_FOUND: begin
          scan_nxt = WOLPM_SCAN_FOUND;
        end
        default: begin
          scan_nxt     = WOLPM_SCAN_SYNC;
          sync_cnt_nxt = 3'h0;
          pos_nxt      = 3'h0;
          copy_cnt_nxt = 5'h00;
        end
      endcase
    end
  end

  // Scanner registers.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      scan_r     <= WOLPM_SCAN_SYNC;
      sync_cnt_r <= 3'h0;
      pos_r      <= 3'h0;
      copy_cnt_r <= 5'h00;
    end else begin
      scan_r     <= scan_nxt;
      sync_cnt_r <= sync_cnt_nxt;
      pos_r      <= pos_nxt;
      copy_cnt_r <= copy_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Wake events and the power management event output.

  logic [NUM_WAKE_FRAMES-1:0] frame_hit;
  logic [CAUSE_W-1:0]         ev;
  logic [CAUSE_W-1:0]         cause_r;
  logic [CAUSE_W-1:0]         cause_nxt;
  logic                       link_prev_r;
  logic                       pme_n_r;
  logic                       magic_hit;
  logic                       eof;

  assign eof = i_rx_end & ~port_pd_r & ~chip_pd_r;

  // Each enabled definition matches when the good FCS equals its stored CRC.
  generate
    for (genvar g = 0; g < NUM_WAKE_FRAMES; g++) begin : g_wf
      assign frame_hit[g] = i_wake_frame_control[g] & frame_ok
                          & (fcs_r == i_wake_crc[g]);  // see R5 R6
    end
  endgenerate

  // Only a complete pattern in a valid frame wakes.
  assign magic_hit = magic_en & frame_ok & (scan_r == WOLPM_SCAN_FOUND);  // see R13 R11

  assign ev[CAUSE_LINK]  = (link_prev_r != i_link_up);  // see R4
  assign ev[CAUSE_FRAME] = eof & (|frame_hit);          // see R4
  assign ev[CAUSE_MAGIC] = eof & magic_hit;             // see R4

  // Causes are sticky until acknowledged; a new event beats the clear.
  assign cause_nxt = (cause_r & ~{CAUSE_W{i_wake_ack}}) | ev;  // see R15

  // Event register; the output stays low while any cause is held.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      cause_r     <= '0;
      link_prev_r <= 1'b0;
      pme_n_r     <= 1'b1;
    end else begin
      cause_r     <= cause_nxt;
      link_prev_r <= i_link_up;
      pme_n_r     <= ~(|cause_nxt);  // see R14
    end
  end

  assign o_power_event_out_n = pme_n_r;
  assign o_wake_cause        = cause_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);

  a_port_pd_follow: assert property (  // see R1
    (i_port_phy_control_four[PORT_CHIP_POWERDOWN_IN_N_BIT] | i_port_basic_control[PORT_CHIP_POWERDOWN_IN_N_BIT])
    |=> o_port_powerdown)
    else $error("Port not powered down by control bit.");
  a_chip_pd_low: assert property (  // see R2
    !i_chip_powerdown_in_n |=> o_chip_powerdown && !o_chip_reset)
    else $error("Chip not powered down while pin low.");
  // The pulse is registered, so it shows one edge after the rise is sampled.
  a_chip_reset_pulse: assert property (  // see R3
    $rose(i_chip_powerdown_in_n) |=> o_chip_reset ##1 !o_chip_reset)
    else $error("Chip reset pulse wrong on pin release.");
  a_link_wakes: assert property (  // see R4
    (i_link_up != link_prev_r) |=> !o_power_event_out_n && o_wake_cause[CAUSE_LINK])
    else $error("Link change did not raise event.");
  a_frame_wakes: assert property (  // see R5
    (eof && i_wake_frame_control[0] && frame_ok && fcs_r == i_wake_crc[0])
    |=> o_wake_cause[CAUSE_FRAME] && !o_power_event_out_n)
    else $error("Wake frame 0 missed.");
  a_magic_enable: assert property (  // see R7
    $rose(o_wake_cause[CAUSE_MAGIC]) |-> $past(magic_en))
    else $error("Pattern wake without enable.");
  a_found_copies: assert property (  // see R8
    (scan_r == WOLPM_SCAN_FOUND) && ($past(scan_r) != WOLPM_SCAN_FOUND)
    |-> copy_cnt_r == ADDR_COPIES)
    else $error("Pattern found with wrong copy count.");
  a_addr_after_sync: assert property (  // see R9
    (scan_r == WOLPM_SCAN_ADDR) && ($past(scan_r) == WOLPM_SCAN_SYNC)
    |-> $past(sync_cnt_r) == SYNC_LEN)
    else $error("Address run without full sync.");
  a_magic_valid: assert property (  // see R11
    $rose(o_wake_cause[CAUSE_MAGIC]) |-> $past(frame_ok && eof && scan_r == WOLPM_SCAN_FOUND))
    else $error("Pattern wake from invalid frame.");
  a_pme_hold: assert property (  // see R15
    !o_power_event_out_n && !i_wake_ack |=> !o_power_event_out_n [*2] or i_wake_ack)
    else $error("Event output dropped without acknowledge.");

  c_magic_wake: cover property (eof && magic_hit ##1 !o_power_event_out_n);
  c_frame_wake: cover property (ev[CAUSE_FRAME]);
  c_scan_restart: cover property ((scan_r == WOLPM_SCAN_ADDR) ##1 (scan_r == WOLPM_SCAN_SYNC));

endmodule
`default_nettype wire

// ### verification/wolpm_rx_model.sv
`timescale 1ns/1ns
`default_nettype none
module wolpm_rx_model (
  // Clock.
  input  wire logic       i_clock,
  // Frame stream toward the block.
  output logic            o_rx_start,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_end
);
  ////////////////////////////////////////////////////////////////////////////////
  // The stream starts idle.
  initial begin
    o_rx_start = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_data  = 8'h00;
    o_rx_end   = 1'b0;
  end

  // Reflected CRC-32 of a byte queue, returned as the value sent on the wire.
  function automatic logic [31:0] fcs_of(input logic [7:0] q[$]);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    foreach (q[i]) begin
      c = c ^ {24'h000000, q[i]};
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
      end
    end
    return ~c;
  endfunction

  // Sends one frame, check bytes last and low byte first, then the end strobe.
  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [31:0] f;
    f = fcs_of(q) ^ {31'h0, bad};
    for (int i = 0; i < 4; i++) begin
      q.push_back(f[i*8 +: 8]);
    end
    @(posedge i_clock);
    #1 o_rx_start = 1'b1;
    @(posedge i_clock);
    #1 o_rx_start = 1'b0;
    foreach (q[i]) begin
      o_rx_valid = 1'b1;
      o_rx_data  = q[i];
      @(posedge i_clock);
      #1;
    end
    // The data lines do not keep the last byte once the frame is over.
    o_rx_valid = 1'b0;
    o_rx_data  = ~o_rx_data;
    o_rx_end   = 1'b1;
    @(posedge i_clock);
    #1 o_rx_end = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### verification/wolpm_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module wolpm_tb_top;
  import wolpm_pkg::*;
  localparam logic [47:0] STATION = 48'h02A1B2C3D4E5;
  typedef struct {
    logic [15:0] four;
    logic [15:0] basic;
    logic [47:0] da;
    int          copies;
    logic        bad;
    logic [7:0]  wfc;
    logic        pd;
    logic [3:0]  exp;
  } wolpm_row_t;
  logic        clock, reset, pin_n, link_up, wake_ack;
  logic        rx_start, rx_valid, rx_end;
  logic        port_pd, chip_pd, chip_rst, event_n;
  logic [15:0] ctl_four, ctl_basic;
  logic [7:0]  wfc, rx_data;
  logic [2:0]  cause;
  logic [31:0] wake_crc [NUM_WAKE_FRAMES];
  logic [7:0]  fr[$];
  int          errors, num_checks, pulses;
  // Rows: controls and frame in, powerdown and {event, causes} out.
  wolpm_row_t  rows [10] = '{
    '{16'h0000, 16'h0000, STATION, 16, 1'b0, 8'h80, 1'b0, 4'h4},
    '{16'h0000, 16'h0000, 48'hFFFFFFFFFFFF, 16, 1'b0, 8'h80, 1'b0, 4'h4},
    '{16'h0000, 16'h0000, 48'h01005E000001, 16, 1'b0, 8'h80, 1'b0, 4'h4},
    '{16'h0000, 16'h0000, 48'h020000000099, 16, 1'b0, 8'h80, 1'b0, 4'h8},
    '{16'h0000, 16'h0000, STATION, 16, 1'b1, 8'h80, 1'b0, 4'h8},
    '{16'h0000, 16'h0000, STATION, 15, 1'b0, 8'h80, 1'b0, 4'h8},
    '{16'h0000, 16'h0000, STATION, 16, 1'b0, 8'h00, 1'b0, 4'h8},
    '{16'h0800, 16'h0000, STATION, 16, 1'b0, 8'h80, 1'b1, 4'h8},
    '{16'h0000, 16'h0800, STATION, 16, 1'b0, 8'h80, 1'b1, 4'h8},
    '{16'hF7FF, 16'hF7FF, STATION, 16, 1'b0, 8'h80, 1'b0, 4'h4}
  };

  ////////////////////////////////////////////////////////////////////////////////
  // Design and frame source.
  wolpm_top dut (
    .i_clock                 (clock),
    .i_reset                 (reset),
    .i_port_phy_control_four (ctl_four),
    .i_port_basic_control    (ctl_basic),
    .i_chip_powerdown_in_n   (pin_n),
    .o_port_powerdown        (port_pd),
    .o_chip_powerdown        (chip_pd),
    .o_chip_reset            (chip_rst),
    .i_wake_frame_control    (wfc),
    .i_wake_crc              (wake_crc),
    .i_station_addr          (STATION),
    .i_rx_start              (rx_start),
    .i_rx_valid              (rx_valid),
    .i_rx_data               (rx_data),
    .i_rx_end                (rx_end),
    .i_link_up               (link_up),
    .i_wake_ack              (wake_ack),
    .o_power_event_out_n     (event_n),
    .o_wake_cause            (cause)
  );
  wolpm_rx_model rx_model (
    .i_clock    (clock),
    .o_rx_start (rx_start),
    .o_rx_valid (rx_valid),
    .o_rx_data  (rx_data),
    .o_rx_end   (rx_end)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock of 4 ns.
  always #2 clock = ~clock;

  // Waits n edges, then steps just past the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Counts one comparison and reports a mismatch.
  task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Builds a frame: address, source, a broken sync run, a full sync run, copies, tail.
  function automatic void build(input logic [47:0] da, input int copies);
    fr = {};
    for (int i = 5; i >= 0; i--) fr.push_back(da[i*8 +: 8]);
    for (int i = 0; i < 6; i++) fr.push_back(8'h40 + 8'(i));
    for (int i = 0; i < 5; i++) fr.push_back(8'hFF);
    fr.push_back(8'h33);
    for (int i = 0; i < 6; i++) fr.push_back(8'hFF);
    for (int c = 0; c < copies; c++) begin
      for (int i = 5; i >= 0; i--) fr.push_back(STATION[i*8 +: 8]);
    end
    fr.push_back(8'h5A);
  endfunction

  // Software acknowledge, then all causes must be gone.
  task automatic ack();
    wake_ack = 1'b1;
    tick(1);
    wake_ack = 1'b0;
    chk({event_n, cause}, 4'h8, "after ack");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #100000;
    errors++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    {pin_n, link_up, wake_ack, ctl_four, ctl_basic, wfc} = {1'b1, 2'b00, 32'h0, 8'h00};
    foreach (wake_crc[k]) wake_crc[k] = 32'h0;
    repeat (4) @(posedge clock);
    #1 reset = 1'b0;
    chk({event_n, cause}, 4'h8, "reset state");
    foreach (rows[r]) begin
      {ctl_four, ctl_basic, wfc} = {rows[r].four, rows[r].basic, rows[r].wfc};
      tick(1);
      chk({3'h0, port_pd}, {3'h0, rows[r].pd}, "port powerdown");
      build(rows[r].da, rows[r].copies);
      rx_model.send(fr, rows[r].bad);
      chk({event_n, cause}, rows[r].exp, "pattern event");
      ack();
    end
    $display("frame rows done");
    // Chip powerdown ignores a pattern frame, then wakes with one reset pulse.
    pin_n = 1'b0;
    tick(1);
    chk({3'h0, chip_pd}, 4'h1, "chip down");
    build(STATION, 16);
    rx_model.send(fr, 1'b0);
    chk({event_n, cause}, 4'h8, "frame while down");
    pin_n = 1'b1;
    pulses = 0;
    repeat (4) begin
      tick(1);
      pulses += int'(chip_rst === 1'b1);
    end
    chk({2'h0, chip_pd, 1'(pulses == 1)}, 4'h1, "power up reset");
    $display("chip power done");
    // Link change in both directions.
    wfc = 8'h00;
    link_up = 1'b1;
    tick(2);
    chk({event_n, cause}, 4'h1, "link up");
    ack();
    link_up = 1'b0;
    tick(2);
    chk({event_n, cause}, 4'h1, "link down");
    ack();
    $display("link done");
    // Each wake frame slot: refused while disabled, taken once enabled.
    build(STATION, 0);
    for (int k = 0; k < NUM_WAKE_FRAMES; k++) begin
      wake_crc[k] = rx_model.fcs_of(fr);
      wfc = 8'h0F & ~(8'h01 << k);
      rx_model.send(fr, 1'b0);
      chk({event_n, cause}, 4'h8, "frame disabled");
      wfc = 8'h01 << k;
      rx_model.send(fr, 1'b0);
      chk({event_n, cause}, 4'h2, "frame match");
      ack();
      wake_crc[k] = 32'h0;
    end
    $display("wake frames done");
    // A reset in mid-run drops a held cause and the event output.
    link_up = 1'b1;
    tick(2);
    chk({event_n, cause}, 4'h1, "cause before reset");
    reset   = 1'b1;
    link_up = 1'b0;
    tick(1);
    chk({event_n, cause}, 4'h8, "mid-run reset");
    chk({1'b0, port_pd, chip_pd, chip_rst}, 4'h0, "reset power outputs");
    reset = 1'b0;
    tick(2);
    chk({event_n, cause}, 4'h8, "after mid-run reset");
    $display("mid-run reset done");
    stop_test();
  end
endmodule
`default_nettype wire
